// ### logic/dsr_pkg.sv
// Package of offsets, field positions, reset values and timing for the status register bank
package dsr_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_RESET_CTL = 8'h01;
    localparam logic [7:0] OFF_GEN_CFG = 8'h02;
    localparam logic [7:0] OFF_SILICON_REVISION = 8'h03;
    localparam logic [7:0] OFF_DEVICE_STATE = 8'h04;
    localparam logic [7:0] OFF_PARITY_LIMIT_UPPER = 8'h05;
    localparam logic [7:0] OFF_PARITY_LIMIT_LOWER = 8'h06;
    localparam logic [7:0] OFF_CTRL_CHANNEL_TIMEOUT_CTL = 8'h07;
    localparam logic [7:0] OFF_I2C_CONTROL_FIRST = 8'h08;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int BIT_CONFIG_RELOAD_TRIGGER = 2;
    localparam int BIT_PARITY_CHECK_EN = 1;
    localparam int BIT_CONFIG_CHECKSUM_OK = 7;
    localparam int BIT_INIT_DONE = 6;
    localparam int BIT_PASS_SEEN = 3;
    localparam int BIT_LOCK_SEEN = 2;
    localparam int LSB_CTRL_CHANNEL_TIMEOUT = 1;
    localparam int BIT_CTRL_CHANNEL_TIMEOUT_OFF = 0;
    localparam int BIT_REMOTE_WRITE_BLOCK = 7;
    localparam int LSB_REVISION = 4;

    // ----------------------------------------
    // Values after reset
    // ----------------------------------------
    localparam logic RST_PARITY_CHECK_EN = 1'b1;
    localparam logic [7:0] RST_PARITY_LIMIT_UPPER = 8'h01;
    localparam logic [7:0] RST_PARITY_LIMIT_LOWER = 8'h00;
    localparam logic [6:0] RST_CTRL_CHANNEL_TIMEOUT = 7'h7f;
    localparam logic RST_CTRL_CHANNEL_TIMEOUT_OFF = 1'b0;
    localparam logic RST_REMOTE_WRITE_BLOCK = 1'b0;
    localparam logic [6:0] RST_I2C_CONTROL_LOW = 7'h1c;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLOCK_MHZ = 100;
    localparam int TIMEOUT_STEP_MS = 2;
    localparam int TIMEOUT_STEP_CYCLES = TIMEOUT_STEP_MS * 1000 * 1000 * CLOCK_MHZ / 1000;
endpackage : dsr_pkg

// ### logic/dsr_status_regs.sv
// Shared status, parity threshold and control-channel watchdog register bank
module dsr_status_regs #(
    parameter int NUM_PORTS = 2,
    parameter int STEP_CYCLES = dsr_pkg::TIMEOUT_STEP_CYCLES,
    parameter logic [3:0] REV_CODE = 4'h5 // Arbitrary value
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic reg_remote_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_wr_rejected_o,
    input wire logic remote_slave_wr_i,
    output logic remote_slave_fwd_o,
    input wire logic [NUM_PORTS-1:0] parity_err_i,
    input wire logic [NUM_PORTS-1:0] parity_cnt_clr_i,
    output logic [NUM_PORTS-1:0] parity_flag_o,
    output logic parity_check_en_o,
    output logic config_reload_o,
    input wire logic cfg_load_done_i,
    input wire logic cfg_cksum_ok_i,
    input wire logic pass_pin_i,
    input wire logic lock_pin_i,
    input wire logic cc_busy_i,
    output logic cc_abort_o
);
    localparam int TW = $clog2(STEP_CYCLES + 1);

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic par_en, next_par_en;
    logic [7:0] thr_hi, next_thr_hi;
    logic [7:0] thr_lo, next_thr_lo;
    logic [6:0] wd_limit, next_wd_limit;
    logic wd_off, next_wd_off;
    logic wr_block, next_wr_block;
    logic [6:0] i2c_low, next_i2c_low;
    logic reload, next_reload;
    logic init_done, next_init_done;
    logic cksum_ok, next_cksum_ok;
    logic pass_meta, pass_sync, lock_meta, lock_sync;
    logic pass_seen, next_pass_seen;
    logic lock_seen, next_lock_seen;
    logic [7:0] rdata, next_rdata;
    logic wr_rej, next_wr_rej;
    logic fwd, next_fwd;
    logic [15:0] cnt [NUM_PORTS];
    logic [15:0] next_cnt [NUM_PORTS];
    logic [NUM_PORTS-1:0] flag, next_flag;
    logic [TW-1:0] tick, next_tick;
    logic [6:0] steps, next_steps;
    logic fired, next_fired;
    logic abort, next_abort;
    logic wr_ok;
    logic rd_status;
    logic [15:0] thr;

    // ----------------------------------------
    // Register access and status
    // ----------------------------------------
    always_comb begin
        wr_ok = reg_wr_i && !(reg_remote_i && wr_block);
        rd_status = reg_rd_i && (reg_addr_i == dsr_pkg::OFF_DEVICE_STATE);
        next_par_en = par_en;
        next_thr_hi = thr_hi;
        next_thr_lo = thr_lo;
        next_wd_limit = wd_limit;
        next_wd_off = wd_off;
        next_wr_block = wr_block;
        next_i2c_low = i2c_low;
        next_reload = 1'b0;
        next_wr_rej = reg_wr_i && reg_remote_i && wr_block;
        next_fwd = remote_slave_wr_i;
        if (wr_ok) begin
            if (reg_addr_i == dsr_pkg::OFF_RESET_CTL) begin
                next_reload = reg_wdata_i[dsr_pkg::BIT_CONFIG_RELOAD_TRIGGER];
            end else if (reg_addr_i == dsr_pkg::OFF_GEN_CFG) begin
                next_par_en = reg_wdata_i[dsr_pkg::BIT_PARITY_CHECK_EN];
            end else if (reg_addr_i == dsr_pkg::OFF_PARITY_LIMIT_UPPER) begin
                next_thr_hi = reg_wdata_i;
            end else if (reg_addr_i == dsr_pkg::OFF_PARITY_LIMIT_LOWER) begin
                next_thr_lo = reg_wdata_i;
            end else if (reg_addr_i == dsr_pkg::OFF_CTRL_CHANNEL_TIMEOUT_CTL) begin
                next_wd_limit = reg_wdata_i[7:dsr_pkg::LSB_CTRL_CHANNEL_TIMEOUT];
                next_wd_off = reg_wdata_i[dsr_pkg::BIT_CTRL_CHANNEL_TIMEOUT_OFF];
            end else if (reg_addr_i == dsr_pkg::OFF_I2C_CONTROL_FIRST) begin
                next_wr_block = reg_wdata_i[dsr_pkg::BIT_REMOTE_WRITE_BLOCK];
                next_i2c_low = reg_wdata_i[6:0];
            end
        end
        // Reload drops the done flag; loader completion sets it again
        next_init_done = init_done;
        next_cksum_ok = cksum_ok;
        if (cfg_load_done_i) begin
            next_init_done = 1'b1;
            next_cksum_ok = cfg_cksum_ok_i;
        end else if (reload) begin
            next_init_done = 1'b0;
            next_cksum_ok = 1'b0;
        end
        // Latched pin copies: a new high wins over the clear on read
        next_pass_seen = pass_sync | (pass_seen & ~rd_status);
        next_lock_seen = lock_sync | (lock_seen & ~rd_status);
        next_rdata = 8'h00;
        if (reg_rd_i) begin
            if (reg_addr_i == dsr_pkg::OFF_GEN_CFG) begin
                next_rdata[dsr_pkg::BIT_PARITY_CHECK_EN] = par_en;
            end else if (reg_addr_i == dsr_pkg::OFF_SILICON_REVISION) begin
                next_rdata[7:dsr_pkg::LSB_REVISION] = REV_CODE;
            end else if (reg_addr_i == dsr_pkg::OFF_DEVICE_STATE) begin
                next_rdata[dsr_pkg::BIT_CONFIG_CHECKSUM_OK] = cksum_ok;
                next_rdata[dsr_pkg::BIT_INIT_DONE] = init_done;
                next_rdata[dsr_pkg::BIT_PASS_SEEN] = pass_sync | pass_seen;
                next_rdata[dsr_pkg::BIT_LOCK_SEEN] = lock_sync | lock_seen;
            end else if (reg_addr_i == dsr_pkg::OFF_PARITY_LIMIT_UPPER) begin
                next_rdata = thr_hi;
            end else if (reg_addr_i == dsr_pkg::OFF_PARITY_LIMIT_LOWER) begin
                next_rdata = thr_lo;
            end else if (reg_addr_i == dsr_pkg::OFF_CTRL_CHANNEL_TIMEOUT_CTL) begin
                next_rdata = {wd_limit, wd_off};
            end else if (reg_addr_i == dsr_pkg::OFF_I2C_CONTROL_FIRST) begin
                next_rdata = {wr_block, i2c_low};
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            par_en <= dsr_pkg::RST_PARITY_CHECK_EN;
            thr_hi <= dsr_pkg::RST_PARITY_LIMIT_UPPER;
            thr_lo <= dsr_pkg::RST_PARITY_LIMIT_LOWER;
            wd_limit <= dsr_pkg::RST_CTRL_CHANNEL_TIMEOUT;
            wd_off <= dsr_pkg::RST_CTRL_CHANNEL_TIMEOUT_OFF;
            wr_block <= dsr_pkg::RST_REMOTE_WRITE_BLOCK;
            i2c_low <= dsr_pkg::RST_I2C_CONTROL_LOW;
            reload <= 1'b0;
            init_done <= 1'b0;
            cksum_ok <= 1'b0;
            pass_meta <= 1'b0;
            pass_sync <= 1'b0;
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
            pass_seen <= 1'b0;
            lock_seen <= 1'b0;
            rdata <= 8'h00;
            wr_rej <= 1'b0;
            fwd <= 1'b0;
        end else begin
            par_en <= next_par_en;
            thr_hi <= next_thr_hi;
            thr_lo <= next_thr_lo;
            wd_limit <= next_wd_limit;
            wd_off <= next_wd_off;
            wr_block <= next_wr_block;
            i2c_low <= next_i2c_low;
            reload <= next_reload;
            init_done <= next_init_done;
            cksum_ok <= next_cksum_ok;
            pass_meta <= pass_pin_i;
            pass_sync <= pass_meta;
            lock_meta <= lock_pin_i;
            lock_sync <= lock_meta;
            pass_seen <= next_pass_seen;
            lock_seen <= next_lock_seen;
            rdata <= next_rdata;
            wr_rej <= next_wr_rej;
            fwd <= next_fwd;
        end
    end

    // ----------------------------------------
    // Parity error counters
    // ----------------------------------------
    always_comb begin
        thr = {next_thr_hi, next_thr_lo};
        for (int p = 0; p < NUM_PORTS; p++) begin
            next_cnt[p] = cnt[p];
            if (parity_cnt_clr_i[p]) begin
                next_cnt[p] = 16'h0000;
            end
            // An error in the clearing cycle still counts
            if (par_en && parity_err_i[p] && (next_cnt[p] != 16'hffff)) begin
                next_cnt[p] = next_cnt[p] + 16'h0001;
            end
            next_flag[p] = (next_cnt[p] >= thr);
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                cnt[p] <= 16'h0000;
            end
            flag <= '0;
        end else begin
            cnt <= next_cnt;
            flag <= next_flag;
        end
    end

    // ----------------------------------------
    // Control-channel watchdog
    // ----------------------------------------
    always_comb begin
        next_tick = tick;
        next_steps = steps;
        next_fired = fired;
        next_abort = 1'b0;
        if (!cc_busy_i || wd_off) begin
            next_tick = '0;
            next_steps = 7'h00;
            next_fired = 1'b0;
        end else if (!fired) begin
            if (tick == TW'(STEP_CYCLES - 1)) begin
                next_tick = '0;
                next_steps = steps + 7'h01;
                if ((steps + 7'h01) >= wd_limit) begin
                    next_abort = 1'b1;
                    next_fired = 1'b1;
                end
            end else begin
                next_tick = tick + TW'(1);
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            tick <= '0;
            steps <= 7'h00;
            fired <= 1'b0;
            abort <= 1'b0;
        end else begin
            tick <= next_tick;
            steps <= next_steps;
            fired <= next_fired;
            abort <= next_abort;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign reg_rdata_o = rdata;
    assign reg_wr_rejected_o = wr_rej;
    assign remote_slave_fwd_o = fwd;
    assign parity_flag_o = flag;
    assign parity_check_en_o = par_en;
    assign config_reload_o = reload;
    assign cc_abort_o = abort;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking dc @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    a_parity_gated: assert property (
        !par_en && !parity_cnt_clr_i[0] |=> $stable(cnt[0]))
        else $error("parity count moved while checking disabled");
    a_cksum_capture: assert property (
        cfg_load_done_i |=> cksum_ok == $past(cfg_cksum_ok_i))
        else $error("checksum status not captured at load end");
    a_init_done_set: assert property (
        cfg_load_done_i |=> init_done ##1 (init_done || $past(reload)))
        else $error("init done not set after load");
    a_pass_latched: assert property (
        pass_sync && !rd_status |=> pass_seen [*1] ##0 (pass_seen || rd_status))
        else $error("pass indication not latched");
    a_lock_latched: assert property (
        lock_seen && !rd_status |=> lock_seen)
        else $error("lock indication lost before read");
    a_limit_reset: assert property (disable iff (1'b0)
        !rst_n_i |=> thr_hi == 8'h01 && thr_lo == 8'h00 && wd_limit == 7'h7f)
        else $error("wrong values after reset");
    a_flag_thresh: assert property (
        ##1 flag[0] == (cnt[0] >= {thr_hi, thr_lo}))
        else $error("parity flag disagrees with threshold");
    a_abort_cause: assert property (
        cc_abort_o |-> $past(cc_busy_i) && !$past(wd_off)
            && $past(steps) + 7'h01 >= $past(wd_limit))
        else $error("abort without expired busy transaction");
    a_wd_stopped: assert property (
        wd_off |=> !cc_abort_o ##1 (!cc_abort_o || !$past(wd_off)))
        else $error("abort while watchdog disabled");
    a_remote_block: assert property (
        reg_wr_i && reg_remote_i && wr_block |=> reg_wr_rejected_o && $stable(thr_hi)
            && $stable(thr_lo) && $stable(wd_limit))
        else $error("remote write not rejected");
    a_slave_fwd: assert property (
        remote_slave_wr_i |=> remote_slave_fwd_o)
        else $error("remote slave access not forwarded");
    a_reload_pulse: assert property (
        reg_wr_i && !reg_remote_i && reg_addr_i == dsr_pkg::OFF_RESET_CTL
            && reg_wdata_i[dsr_pkg::BIT_CONFIG_RELOAD_TRIGGER] |=> config_reload_o
            ##1 (!init_done || $past(cfg_load_done_i)))
        else $error("reload request missing");

    c_flag_set: cover property (!flag[0] ##1 flag[0]);
    c_abort: cover property (cc_abort_o);
    c_reject: cover property (reg_wr_rejected_o);
    c_reload_done: cover property (config_reload_o ##[1:20] init_done);
endmodule // dsr_status_regs

// ### sim/dsr_host_model.sv
// Register host on the far side of the status bank, local or remote
module dsr_host_model (
    input wire logic clock_i,
    input wire logic [7:0] reg_rdata_i,
    output logic [7:0] reg_addr_o,
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic reg_remote_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_addr_o = 8'h00;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_remote_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // Idle bus shows inverted values so a stale address is never mistaken for a live one
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic rem);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_remote_o <= rem;
        reg_wr_o <= 1'b1;
        @(posedge clock_i);
        reg_wr_o <= 1'b0;
        reg_remote_o <= 1'b0;
        reg_addr_o <= ~a;
        reg_wdata_o <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge clock_i);
        reg_rd_o <= 1'b0;
        reg_addr_o <= ~a;
        #1 d = reg_rdata_i;
    endtask
endmodule // dsr_host_model

// ### sim/dsr_status_regs_tb.sv
// Self-checking testbench of the status register bank
module dsr_status_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] REV = 4'h3; // Arbitrary value
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, remote, rejected, rs_wr = 1'b0, rs_fwd, en, reload, done = 1'b0, ck = 1'b0;
    logic pass = 1'b0, lock = 1'b0, busy = 1'b0, abort;
    logic [1:0] perr = 2'b00, pclr = 2'b00, flag;
    int err_count = 0;
    int n_checks = 0;
    int cyc = 0, n_abort = 0, abort_cyc = 0, n_reload = 0;

    always #5 clock_i = ~clock_i;

    dsr_host_model u_dsr_host_model (.clock_i(clock_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_remote_o(remote), .reg_wdata_o(wdata));

    dsr_status_regs #(.NUM_PORTS(2), .STEP_CYCLES(10), .REV_CODE(REV)) u_dsr_status_regs (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_remote_i(remote), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .reg_wr_rejected_o(rejected), .remote_slave_wr_i(rs_wr), .remote_slave_fwd_o(rs_fwd),
        .parity_err_i(perr), .parity_cnt_clr_i(pclr), .parity_flag_o(flag),
        .parity_check_en_o(en), .config_reload_o(reload), .cfg_load_done_i(done),
        .cfg_cksum_ok_i(ck), .pass_pin_i(pass), .lock_pin_i(lock), .cc_busy_i(busy),
        .cc_abort_o(abort));

    // Event counters for the one-cycle pulses
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (abort === 1'b1) begin
            n_abort <= n_abort + 1;
            abort_cyc <= cyc;
        end
        if (reload === 1'b1) n_reload <= n_reload + 1;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_settle(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic test_reset_values();
        logic [7:0] offs [7] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0a};
        logic [7:0] exps [7] = '{8'h00, {REV, 4'h0}, 8'h00, 8'h01, 8'h00, 8'hfe, 8'h00};
        chk("parity_en_reset", en, 1'b1);
        for (int i = 0; i < 7; i++) begin
            u_dsr_host_model.rd(offs[i], d);
            chk("reset_value", d, exps[i]);
        end
        u_dsr_host_model.rd(8'h08, d);
        chk("block_reset", d[7], 1'b0);
        u_dsr_host_model.rd(8'h02, d);
        chk("parity_en_read", d, 8'h02);
        $display("test reset_values done");
    endtask

    task automatic pulse_err(input logic [1:0] m, input int n);
        repeat (n) begin
            @(posedge clock_i);
            perr <= m;
            @(posedge clock_i);
            perr <= 2'b00;
        end
        wait_settle(2);
    endtask

    task automatic test_parity();
        u_dsr_host_model.wr(8'h05, 8'h00, 1'b0);
        u_dsr_host_model.wr(8'h06, 8'h03, 1'b0);
        pulse_err(2'b01, 2);
        chk("flag_below", flag, 2'b00);
        pulse_err(2'b01, 1);
        chk("flag_at", flag, 2'b01);
        u_dsr_host_model.wr(8'h06, 8'h04, 1'b0);
        wait_settle(2);
        chk("flag_new_limit", flag, 2'b00);
        u_dsr_host_model.wr(8'h02, 8'h00, 1'b0);
        wait_settle(2);
        chk("parity_en_off", en, 1'b0);
        pulse_err(2'b11, 3);
        chk("flag_disabled", flag, 2'b00);
        u_dsr_host_model.wr(8'h02, 8'h02, 1'b0);
        pulse_err(2'b01, 1);
        chk("flag_reenabled", flag, 2'b01);
        @(posedge clock_i);
        pclr <= 2'b01;
        @(posedge clock_i);
        pclr <= 2'b00;
        wait_settle(2);
        chk("flag_cleared", flag, 2'b00);
        $display("test parity done");
    endtask

    task automatic test_watchdog();
        int start;
        u_dsr_host_model.wr(8'h07, 8'h04, 1'b0); // Timeout of two steps, never zero
        @(posedge clock_i);
        busy <= 1'b1;
        start = cyc;
        wait_settle(40);
        chk("abort_count", n_abort, 1);
        chk("abort_time", (abort_cyc - start >= 19) && (abort_cyc - start <= 22), 1'b1);
        @(posedge clock_i);
        busy <= 1'b0;
        u_dsr_host_model.wr(8'h07, 8'h05, 1'b0);
        @(posedge clock_i);
        busy <= 1'b1;
        wait_settle(50);
        @(posedge clock_i);
        busy <= 1'b0;
        chk("abort_when_off", n_abort, 1);
        $display("test watchdog done");
    endtask

    task automatic test_remote_block();
        u_dsr_host_model.wr(8'h08, 8'h9c, 1'b0);
        u_dsr_host_model.wr(8'h05, 8'haa, 1'b1);
        #1 chk("remote_rejected", rejected, 1'b1);
        u_dsr_host_model.rd(8'h05, d);
        chk("limit_kept", d, 8'h00);
        @(posedge clock_i);
        rs_wr <= 1'b1;
        @(posedge clock_i);
        rs_wr <= 1'b0;
        #1 chk("slave_forwarded", rs_fwd, 1'b1);
        u_dsr_host_model.wr(8'h08, 8'h1c, 1'b1);
        u_dsr_host_model.rd(8'h08, d);
        chk("block_kept", d, 8'h9c);
        u_dsr_host_model.wr(8'h08, 8'h1c, 1'b0);
        u_dsr_host_model.wr(8'h05, 8'h55, 1'b1);
        #1 chk("remote_accepted", rejected, 1'b0);
        u_dsr_host_model.rd(8'h05, d);
        chk("limit_remote", d, 8'h55);
        $display("test remote_block done");
    endtask

    task automatic load_done(input logic ok);
        @(posedge clock_i);
        done <= 1'b1;
        ck <= ok;
        @(posedge clock_i);
        done <= 1'b0;
    endtask

    task automatic test_status();
        load_done(1'b1);
        @(posedge clock_i);
        pass <= 1'b1;
        lock <= 1'b1;
        repeat (2) @(posedge clock_i);
        pass <= 1'b0;
        lock <= 1'b0;
        wait_settle(4);
        u_dsr_host_model.rd(8'h04, d);
        chk("status_latched", d, 8'hcc);
        u_dsr_host_model.rd(8'h04, d);
        chk("status_after_read", d, 8'hc0);
        u_dsr_host_model.wr(8'h01, 8'h04, 1'b0);
        wait_settle(3);
        chk("reload_pulse", n_reload, 1);
        u_dsr_host_model.rd(8'h04, d);
        chk("status_reloading", d, 8'h00);
        u_dsr_host_model.rd(8'h01, d);
        chk("reload_self_clear", d, 8'h00);
        load_done(1'b0);
        u_dsr_host_model.rd(8'h04, d);
        chk("status_bad_sum", d, 8'h40);
        $display("test status done");
    endtask

    task automatic test_mid_reset();
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        rst_n_i <= 1'b1;
        u_dsr_host_model.rd(8'h05, d);
        chk("upper_after_reset", d, 8'h01);
        u_dsr_host_model.rd(8'h07, d);
        chk("timeout_after_reset", d, 8'hfe);
        u_dsr_host_model.rd(8'h04, d);
        chk("status_after_reset", d, 8'h00);
        $display("test mid_reset done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock_i);
        err_count++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        test_reset_values();
        test_parity();
        test_watchdog();
        test_remote_block();
        test_status();
        test_mid_reset();
        wrap_up();
    end
endmodule // dsr_status_regs_tb
